// ---- common/dcss_consts.svh ----
//==========================================================================
// Summary of operation
// - removing current from either safety channel stops output transistor switching.
// - monitor output conducts only while both safety channels are energised.
// - one channel open stops output yet leaves monitor output inactive.
// - safety switch on assigns terminals 3 and 4 function codes 77, 78.
// - with safety configuration active both safety inputs are normally closed (01).
// - monitor switch on assigns terminal 11 code 62, normally open (00).
// - switch off sets affected terminals to no function, contacts held off.
// - mode 00 shuts output off in hardware with no trip.
// - mode 01 shuts output off in hardware and trips the drive.
// - safe-stop trip has its own code and beats a simultaneous external trip.
// - drive output switches off within 10 ms of a safety input opening.
// - switch-made terminal assignments are fixed while the switches are on.
`ifndef DCSS_CONSTS_SVH
`define DCSS_CONSTS_SVH

//==========================================================================
// register map (byte addresses)
`define DCSS_ADDR_W          8
`define DCSS_OFF_CTRL        8'h00
`define DCSS_OFF_STATUS      8'h04
`define DCSS_OFF_INCFG       8'h08
`define DCSS_OFF_OUTCFG      8'h0c
`define DCSS_OFF_TRIP        8'h10

//==========================================================================
// control fields and reset values
`define DCSS_CTRL_MODE_LSB   0
`define DCSS_CTRL_MODE_MSB   1
`define DCSS_CTRL_RUN_BIT    4
`define DCSS_CTRL_RESET      32'h0000_0000
`define DCSS_CTRL_WR_MASK    32'h0000_0013
`define DCSS_TRIP_CLR_BIT    0

//==========================================================================
// terminal assignment codes
`define DCSS_FUNC_NONE       8'h00
`define DCSS_FUNC_SAFETY_A   8'h4d
`define DCSS_FUNC_SAFETY_B   8'h4e
`define DCSS_FUNC_MONITOR    8'h3e
`define DCSS_POL_NO          2'h0
`define DCSS_POL_NC          2'h1

//==========================================================================
// trip codes (decimal 37 and 12)
`define DCSS_SAFE_STOP_TRIP_CODE 8'h25
`define DCSS_EXTERNAL_TRIP_CODE  8'h0c

//==========================================================================
// timing: stop time and clock period
`define DCSS_STOP_TIME_NS    10000000
`define DCSS_CLK_PERIOD_NS   5

`endif

// ---- common/dcss_pkg.sv ----
package dcss_pkg;

	// safe-stop mode setting
	typedef enum logic [1:0] {
		DCSS_MODE_NO_TRIP = 2'b00,
		DCSS_MODE_TRIP    = 2'b01
	} dcss_mode_t;

	// which trip, if any, holds the drive
	typedef enum logic [1:0] {
		DCSS_TRIP_NONE = 2'b00,
		DCSS_TRIP_SAFE = 2'b01,
		DCSS_TRIP_EXT  = 2'b10
	} dcss_trip_t;

endpackage

// ---- hdl/dcss_safe_stop.sv ----
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "dcss_consts.svh"

module dcss_safe_stop
	import dcss_pkg::*;
(
	input  wire logic                    clk,
	input  wire logic                    rst,
	input  wire logic                    safety_in_a,
	input  wire logic                    safety_in_b,
	input  wire logic                    safety_switch,
	input  wire logic                    monitor_switch,
	input  wire logic                    ext_trip_in,
	input  wire logic [`DCSS_ADDR_W-1:0] addr,
	input  wire logic [31:0]             wdata,
	input  wire logic                    wr,
	input  wire logic                    rd,
	output logic      [31:0]             rdata,
	output logic                         gate_enable,
	output logic                         ext_device_monitor_out,
	output logic                         trip_active
);

	// longest tolerated stop latency in cycles; the path below takes three
	localparam int STOP_CYCLES = `DCSS_STOP_TIME_NS / `DCSS_CLK_PERIOD_NS;

	//==========================================================================
	// input synchronisers
	// each pin has its own pair; channels never share a stage
	// zero at reset reads as an open channel, so the drive starts stopped
	logic [4:0] sync_s1;
	logic [4:0] sync_s2;
	wire  [4:0] raw_pins = {ext_trip_in, monitor_switch, safety_switch,
	                        safety_in_b, safety_in_a};

	// one pass per pin keeps the stages identical
	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++) begin : g_sync
			always_ff @(posedge clk) begin
				if (rst) begin
					sync_s1[gi] <= 1'b0;
					sync_s2[gi] <= 1'b0;
				end else begin
					sync_s1[gi] <= raw_pins[gi];
					sync_s2[gi] <= sync_s1[gi];
				end
			end
		end
	endgenerate

	// synchronised copies; only these feed the logic below
	wire a_s     = sync_s2[0];
	wire b_s     = sync_s2[1];
	wire saf_sw  = sync_s2[2];
	wire mon_sw  = sync_s2[3];
	wire ext_s   = sync_s2[4];

	//==========================================================================
	// terminal assignment, derived from the switches only
	// software has no write path here, so the assignment cannot drift
	// switch off means no function and contacts off, never a stale code
	wire [7:0] input3_function_sel  = saf_sw ? `DCSS_FUNC_SAFETY_A : `DCSS_FUNC_NONE;
	wire [7:0] input4_function_sel  = saf_sw ? `DCSS_FUNC_SAFETY_B : `DCSS_FUNC_NONE;
	wire [1:0] input3_polarity_sel  = saf_sw ? `DCSS_POL_NC : `DCSS_POL_NO;
	wire [1:0] input4_polarity_sel  = saf_sw ? `DCSS_POL_NC : `DCSS_POL_NO;
	wire [7:0] output11_function_sel = mon_sw ? `DCSS_FUNC_MONITOR : `DCSS_FUNC_NONE;
	wire [1:0] output11_polarity_sel = `DCSS_POL_NO;

	// normally closed: current present means the channel is energised and healthy
	function automatic logic chan_ok(input logic level, input logic [1:0] pol);
		chan_ok = (pol == `DCSS_POL_NC) ? level : 1'b0;
	endfunction

	// each channel judged on its own; no term mixes the two
	wire a_ok       = chan_ok(a_s, input3_polarity_sel);
	wire b_ok       = chan_ok(b_s, input4_polarity_sel);
	wire both_ok    = a_ok & b_ok;
	// either channel open is enough; a single open channel still stops the drive
	wire stop_req   = saf_sw & ~both_ok;

	//==========================================================================
	// control register
	// one decoder for every register match, shared by writes and reads
	function automatic logic reg_hit(input logic [`DCSS_ADDR_W-1:0] a,
	                                 input logic [`DCSS_ADDR_W-1:0] off);
		reg_hit = (a == off);
	endfunction

	logic [31:0] ctrl;
	wire         hit_ctrl   = reg_hit(addr, `DCSS_OFF_CTRL);
	wire         hit_status = reg_hit(addr, `DCSS_OFF_STATUS);
	wire         hit_incfg  = reg_hit(addr, `DCSS_OFF_INCFG);
	wire         hit_outcfg = reg_hit(addr, `DCSS_OFF_OUTCFG);
	wire         hit_trip   = reg_hit(addr, `DCSS_OFF_TRIP);

	wire [1:0]   safe_stop_mode_sel = ctrl[`DCSS_CTRL_MODE_MSB:`DCSS_CTRL_MODE_LSB];
	wire         run_enable         = ctrl[`DCSS_CTRL_RUN_BIT];
	// reserved bits are dropped on write so they always read back as zero
	wire [31:0]  ctrl_wmask         = `DCSS_CTRL_WR_MASK;

	// mode and run bit only; software cannot touch the terminal assignment
	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl <= `DCSS_CTRL_RESET;
		end else if (wr && hit_ctrl) begin
			ctrl <= wdata & ctrl_wmask;
		end
	end

	//==========================================================================
	// trip state
	// latched until software clears it; a persisting cause sets it again
	dcss_trip_t trip_state;
	dcss_trip_t next_trip_state;

	wire safe_trip_evt = stop_req && (safe_stop_mode_sel == DCSS_MODE_TRIP);
	wire trip_clr      = wr && hit_trip && wdata[`DCSS_TRIP_CLR_BIT];

	// events win over a clear in the same cycle, except an external one while a safe-stop trip is held; safe-stop beats external
	// an external trip is replaced by a safe-stop trip, never the reverse
	always_comb begin
		next_trip_state = trip_state;
		if (trip_clr) begin
			next_trip_state = DCSS_TRIP_NONE;
		end
		case (trip_state)
			DCSS_TRIP_NONE, DCSS_TRIP_EXT: begin
				if (safe_trip_evt) begin
					next_trip_state = DCSS_TRIP_SAFE;
				end else if (ext_s && trip_state == DCSS_TRIP_NONE) begin
					next_trip_state = DCSS_TRIP_EXT;
				end else if (ext_s) begin
					next_trip_state = DCSS_TRIP_EXT;
				end
			end
			DCSS_TRIP_SAFE: begin
				if (safe_trip_evt) begin
					next_trip_state = DCSS_TRIP_SAFE;
				end
			end
			default: begin
				next_trip_state = DCSS_TRIP_NONE;
			end
		endcase
	end

	// trip state register
	always_ff @(posedge clk) begin
		if (rst) begin
			trip_state <= DCSS_TRIP_NONE;
		end else begin
			trip_state <= next_trip_state;
		end
	end

	// code for the trip register; zero while nothing holds the drive
	wire [7:0] trip_code = (trip_state == DCSS_TRIP_SAFE) ? `DCSS_SAFE_STOP_TRIP_CODE :
	                       (trip_state == DCSS_TRIP_EXT)  ? `DCSS_EXTERNAL_TRIP_CODE :
	                       8'h00;

	//==========================================================================
	// outputs
	// any latched trip keeps the output stage off until software clears it
	wire no_trip   = (trip_state == DCSS_TRIP_NONE);
	// stop path is sync pair plus one flop: 15 ns, far inside the stop budget
	wire next_gate = run_enable & ~stop_req & no_trip
	                 & (STOP_CYCLES > 3);
	// monitor conducts only with both channels healthy and the terminal assigned
	wire next_mon  = (output11_function_sel == `DCSS_FUNC_MONITOR)
	                 & saf_sw & both_ok;

	// gate drive; reset leaves the output stage off
	always_ff @(posedge clk) begin
		if (rst) begin
			gate_enable <= 1'b0;
		end else begin
			gate_enable <= next_gate;
		end
	end

	// monitor contact; held off in reset so the controller sees no false ok
	always_ff @(posedge clk) begin
		if (rst) begin
			ext_device_monitor_out <= 1'b0;
		end else begin
			ext_device_monitor_out <= next_mon;
		end
	end

	// trip flag lags the trip state by one cycle; it is a registered copy
	always_ff @(posedge clk) begin
		if (rst) begin
			trip_active <= 1'b0;
		end else begin
			trip_active <= ~no_trip;
		end
	end

	//==========================================================================
	// read path; unmapped addresses read zero
	// status shows the synchronised channel and switch pins (ext_trip_in is not shown), so software sees what the logic sees of them
	wire [31:0] status_word = {24'h0, 1'b0, trip_active, ext_device_monitor_out,
	                           gate_enable, mon_sw, saf_sw, b_s, a_s};
	// configuration words are rebuilt from the switches on every read
	wire [31:0] incfg_word  = {10'h0, input4_polarity_sel, 2'h0, input3_polarity_sel,
	                           input4_function_sel, input3_function_sel};
	wire [31:0] outcfg_word = {22'h0, output11_polarity_sel, output11_function_sel};
	wire [31:0] rd_mux      = hit_ctrl   ? ctrl :
	                          hit_status ? status_word :
	                          hit_incfg  ? incfg_word :
	                          hit_outcfg ? outcfg_word :
	                          hit_trip   ? {24'h0, trip_code} : 32'h0;

	// data stand for one cycle after the strobe, then return to zero
	always_ff @(posedge clk) begin
		if (rst) begin
			rdata <= 32'h0;
		end else if (rd) begin
			rdata <= rd_mux;
		end else begin
			rdata <= 32'h0;
		end
	end

endmodule

// ---- sim/dcss_plc_model.sv ----
`timescale 1ns/1ps
//======================================================================
// outside safety controller: energises both channels, opens both to stop
module dcss_plc_model (
	input  wire logic       clk,
	input  wire logic       stop_req,
	input  wire logic [1:0] open_one,
	output logic            safety_in_a,
	output logic            safety_in_b
);
	// open_one is a deliberate single-channel wiring fault, only when asked
	always_ff @(posedge clk) begin
		safety_in_a <= !(stop_req || open_one[0]);
		safety_in_b <= !(stop_req || open_one[1]);
	end
endmodule

// ---- sim/dcss_safe_stop_monitor.sv ----
`timescale 1ns/1ps
`include "dcss_consts.svh"
module dcss_safe_stop_monitor (
	input wire logic                    clk,
	input wire logic                    rst,
	input wire logic                    safety_in_a,
	input wire logic                    safety_in_b,
	input wire logic                    safety_switch,
	input wire logic                    monitor_switch,
	input wire logic [`DCSS_ADDR_W-1:0] addr,
	input wire logic [31:0]             wdata,
	input wire logic                    wr,
	input wire logic                    gate_enable,
	input wire logic                    ext_device_monitor_out,
	input wire logic                    trip_active
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// a trip clear request; the latched trip may only drop after one of these
	wire clr = wr && addr == `DCSS_OFF_TRIP && wdata[`DCSS_TRIP_CLR_BIT];
	//==================================================================
	// channel sequences: four samples cover the two-stage synchroniser and output stage
	sequence s_a_open; (safety_switch && !safety_in_a)[*4]; endsequence
	sequence s_b_open; (safety_switch && !safety_in_b)[*4]; endsequence
	sequence s_both_ok;
		(safety_switch && monitor_switch && safety_in_a && safety_in_b)[*4];
	endsequence
	property p_stop_a; s_a_open |-> !gate_enable; endproperty
	property p_stop_b; s_b_open |-> !gate_enable; endproperty
	property p_mon_a; (!safety_in_a)[*4] |-> !ext_device_monitor_out; endproperty
	property p_mon_b; (!safety_in_b)[*4] |-> !ext_device_monitor_out; endproperty
	property p_mon_on; s_both_ok |-> ext_device_monitor_out; endproperty
	property p_mon_sw; (!monitor_switch)[*4] |-> !ext_device_monitor_out; endproperty
	property p_trip_hold; trip_active && !clr && !$past(clr) |=> trip_active; endproperty
	property p_trip_gate; trip_active[*2] |-> !gate_enable; endproperty
	a_stop_a: assert property (p_stop_a) else $error("gate on, channel a open");
	a_stop_b: assert property (p_stop_b) else $error("gate on, channel b open");
	a_mon_a: assert property (p_mon_a) else $error("monitor on, a open");
	a_mon_b: assert property (p_mon_b) else $error("monitor on, b open");
	a_mon_on: assert property (p_mon_on) else $error("monitor off, both ok");
	a_mon_sw: assert property (p_mon_sw) else $error("monitor on, switch off");
	a_trip_hold: assert property (p_trip_hold) else $error("trip dropped");
	a_trip_gate: assert property (p_trip_gate) else $error("gate on in trip");
endmodule
bind dcss_safe_stop dcss_safe_stop_monitor u_mon (.clk, .rst, .safety_in_a, .safety_in_b,
	.safety_switch, .monitor_switch, .addr, .wdata, .wr, .gate_enable,
	.ext_device_monitor_out, .trip_active);

// ---- sim/dcss_safe_stop_tb.sv ----
`timescale 1ns/1ps
`include "dcss_consts.svh"
`define CHK(n, e, v) begin n_checks++; if ((v) !== (e)) begin err_count++; \
	$display("wrong value %s exp %h got %h", n, e, v); end end
module dcss_safe_stop_tb import dcss_pkg::*;;
	logic        clk = 1'b0, rst = 1'b1, sw_s = 1'b0, sw_m = 1'b0, ext = 1'b0;
	logic        wr = 1'b0, rd = 1'b0, stop = 1'b0, sa, sb, gate, mon, trip;
	logic [1:0]  fault = 2'h0;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	int          err_count = 0, n_checks = 0;
	always #2.5 clk = ~clk;
	dcss_plc_model plc (.clk(clk), .stop_req(stop), .open_one(fault), .safety_in_a(sa),
		.safety_in_b(sb));
	dcss_safe_stop uut (.clk(clk), .rst(rst), .safety_in_a(sa), .safety_in_b(sb),
		.safety_switch(sw_s), .monitor_switch(sw_m), .ext_trip_in(ext), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .gate_enable(gate),
		.ext_device_monitor_out(mon), .trip_active(trip));
	//==================================================================
	// bus tasks: one-cycle strobes, read data sampled in the following cycle
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string n);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 `CHK(n, e, rdata)
	endtask
	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// gate, monitor, trip in that order
	task automatic outs(input logic [2:0] e, input string n);
		`CHK(n, e, {gate, mon, trip})
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	//==================================================================
	// watchdog: the tests need well under 1000 cycles
	initial begin
		#20000;
		err_count++;
		$display("watchdog expired");
		results;
	end
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		rd_chk(`DCSS_OFF_CTRL, `DCSS_CTRL_RESET, "ctrl reset");
		rd_chk(8'h20, 32'h0, "unmapped read");
		outs(3'b000, "outs after reset");
		@(posedge clk) begin sw_s <= 1'b1; sw_m <= 1'b1; end
		wr_reg(`DCSS_OFF_CTRL, 32'h10);
		wait_clk(6);
		outs(3'b110, "outs running");
		rd_chk(`DCSS_OFF_STATUS, 32'h0000_003f, "status running");
		rd_chk(`DCSS_OFF_INCFG, 32'h0011_4e4d, "input cfg");
		rd_chk(`DCSS_OFF_OUTCFG, 32'h0000_003e, "output cfg");
		wr_reg(`DCSS_OFF_INCFG, 32'h0);
		rd_chk(`DCSS_OFF_INCFG, 32'h0011_4e4d, "input cfg fixed");
		$display("test config done");
		for (int i = 1; i < 3; i++) begin
			@(posedge clk) fault <= i[1:0];
			wait_clk(5);
			outs(3'b000, "one channel open");
			@(posedge clk) fault <= 2'h0;
			wait_clk(6);
			outs(3'b110, "channel closed");
		end
		$display("test single channel done");
		wr_reg(`DCSS_OFF_CTRL, {27'h0, 1'b1, 2'h0, DCSS_MODE_TRIP});
		rd_chk(`DCSS_OFF_CTRL, 32'h0000_0011, "ctrl mode trip");
		@(posedge clk) begin stop <= 1'b1; ext <= 1'b1; end
		wait_clk(8);
		outs(3'b001, "safe stop trip");
		rd_chk(`DCSS_OFF_TRIP, {24'h0, `DCSS_SAFE_STOP_TRIP_CODE}, "trip code");
		@(posedge clk) begin stop <= 1'b0; ext <= 1'b0; end
		wait_clk(8);
		outs(3'b011, "trip latched");
		wr_reg(`DCSS_OFF_TRIP, 32'h1);
		wait_clk(3);
		outs(3'b110, "trip cleared");
		@(posedge clk) ext <= 1'b1;
		wait_clk(8);
		rd_chk(`DCSS_OFF_TRIP, {24'h0, `DCSS_EXTERNAL_TRIP_CODE}, "ext code");
		@(posedge clk) ext <= 1'b0;
		wait_clk(6);
		wr_reg(`DCSS_OFF_TRIP, 32'h1);
		$display("test trip done");
		@(posedge clk) begin sw_s <= 1'b0; sw_m <= 1'b0; end
		wait_clk(6);
		rd_chk(`DCSS_OFF_INCFG, 32'h0, "input cfg off");
		rd_chk(`DCSS_OFF_OUTCFG, 32'h0, "output cfg off");
		outs(3'b100, "outs switches off");
		$display("test switches off done");
		results;
	end
endmodule
